//--- shared/rcs_cfg.svh
// constants for the reset cause status logic
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
`define RCS_PC_W          21
`define RCS_PC_RESET      21'h000000
`define RCS_PC_STEP       21'h000002
`define RCS_VEC_HIGH      21'h000008
`define RCS_VEC_LOW       21'h000018
`define RCS_BOR_CFG_SW    2'h1
// defined-reset example register: reset value in all reset cases
`define RCS_DEF_W         8
`define RCS_DEF_RST_POR   8'h00
`define RCS_DEF_RST_OTHER 8'h00
`endif

//--- shared/rcs_pkg.sv
// types for the reset cause status logic
package rcs_pkg;
  // reset value groups
  typedef enum logic [1:0] {
    RCS_GRP_NONE,
    RCS_GRP_POWER,
    RCS_GRP_RESET,
    RCS_GRP_WAKE
  } rcs_group_t;

  // power mode of the core when an event arrives
  typedef enum logic [1:0] {
    RCS_MODE_FULL,
    RCS_MODE_RUN,
    RCS_MODE_IDLE,
    RCS_MODE_SLEEP
  } rcs_mode_t;

  typedef struct packed {
    logic        ri;
    logic        to;
    logic        pd;
    logic        po;
    logic        bo;
    logic        sf;
    logic        su;
    logic        sbo;
    logic [20:0] pc;
    logic        pc_load;
    rcs_group_t  grp;
    logic [7:0]  defreg;
    logic [7:0]  keepreg;
  } rcs_state_t;
endpackage

//--- design/rcs_top.sv
// reset cause flags, program counter load and register reset values
// What this block does
// - undefined registers keep value across non-power resets
// - defined registers load value chosen by reset
// - watchdog wake-up leaves most registers untouched
// - power-on: pc zero, flags set, others cleared
// - brown-out: pc zero, flags set, brownout cleared
// - reset instruction clears reset-instruction flag
// - pin reset in run sets timeout flag
// - pin reset in idle/sleep also clears powerdown
// - watchdog in run clears timeout flag
// - pin reset at full power keeps flags
// - enabled stack full reset sets full flag
// - enabled stack underflow reset sets underflow flag
// - disabled underflow sets underflow flag and zeroes pc without a load
// - watchdog wake-up: pc plus two, clear timeout and powerdown flags
// - interrupt wake-up: pc plus two, clear powerdown
// - enabled interrupt wake-up loads interrupt vector
// - software brownout enable reset value by config
// - reset values grouped in three cases
// - software brownout enable reads zero unless configured
`include "rcs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rcs_top #(
  parameter int PC_W  = `RCS_PC_W,
  parameter int DEF_W = `RCS_DEF_W
) (
  input  wire logic            CLK_I,
  input  wire logic            SYS_RST_I,
  input  wire logic            POR_I,
  input  wire logic            BOR_I,
  input  wire logic            MASTER_CLEAR_PIN_I,
  input  wire logic            RESET_INSTR_I,
  input  wire logic            WDT_TIMEOUT_I,
  input  wire logic            STACK_FULL_I,
  input  wire logic            STACK_UNDERFLOW_I,
  input  wire logic            IRQ_WAKE_I,
  input  wire logic [1:0]      POWER_MODE_I,
  input  wire logic            STACK_OVERFLOW_RESET_ENABLE_CFG_I,
  input  wire logic [1:0]      BOR_CFG_I,
  input  wire logic            HIGH_IRQ_EN_I,
  input  wire logic            LOW_IRQ_EN_I,
  input  wire logic            IRQ_HIGH_I,
  input  wire logic [PC_W-1:0] CUR_PC_I,
  input  wire logic            SW_WR_I,
  input  wire logic [7:0]      SW_WDATA_I,
  input  wire logic [7:0]      SW_WMASK_I,
  input  wire logic [DEF_W-1:0] DEF_WDATA_I,
  output logic                 RESET_INSTR_FLAG_O,
  output logic                 WDT_TIMEOUT_FLAG_O,
  output logic                 POWERDOWN_FLAG_O,
  output logic                 POWERON_FLAG_O,
  output logic                 BROWNOUT_FLAG_O,
  output logic                 STACK_FULL_FLAG_O,
  output logic                 STACK_UNDERFLOW_FLAG_O,
  output logic                 SW_BOR_EN_O,
  output logic [PC_W-1:0]      PC_O,
  output logic                 PC_LOAD_O,
  output logic                 CORE_RESET_O,
  output logic [1:0]           RESET_GROUP_O,
  output logic [DEF_W-1:0]     DEF_REG_O,
  output logic [DEF_W-1:0]     KEEP_REG_O
);

  ////////////////////////////////////////////////////////////////////////
  // por and bor pass two flops, the master clear pin three; ev_por reads the second stage por_s1_q[1] directly
  logic [1:0] master_clear_pin_s1_q;
  logic [1:0] por_s1_q;
  logic       master_clear_pin_s2_q;
  logic       master_clear_pin_s3_q;
  logic       por_s2_q;
  logic       por_s3_q;
  logic       bor_s1_q;
  logic       bor_s2_q;
  logic       bor_s3_q;

  // edge detect on synchronised pins so a held pin makes one event
  always_ff @(posedge CLK_I) begin
    master_clear_pin_s1_q <= {master_clear_pin_s1_q[0], MASTER_CLEAR_PIN_I};
    por_s1_q  <= {por_s1_q[0], POR_I};
    bor_s1_q  <= BOR_I;
    bor_s2_q  <= bor_s1_q;
    master_clear_pin_s2_q <= master_clear_pin_s1_q[1];
    por_s2_q  <= por_s1_q[1];
    bor_s3_q  <= bor_s2_q;
    master_clear_pin_s3_q <= master_clear_pin_s2_q;
    por_s3_q  <= por_s2_q;
  end

  logic ev_por;
  logic ev_bor;
  logic ev_master_clear_pin;
  assign ev_por  = por_s1_q[1] & ~por_s2_q;
  assign ev_bor  = bor_s2_q & ~bor_s3_q;
  assign ev_master_clear_pin = master_clear_pin_s2_q & ~master_clear_pin_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // state
  rcs_pkg::rcs_state_t st_q;
  rcs_pkg::rcs_state_t st_d;
  rcs_pkg::rcs_mode_t  mode;
  logic                pm_low;
  logic                sw_bor_mode;

  assign mode        = rcs_pkg::rcs_mode_t'(POWER_MODE_I);
  assign pm_low      = (mode == rcs_pkg::RCS_MODE_IDLE) ||
                       (mode == rcs_pkg::RCS_MODE_SLEEP);
  assign sw_bor_mode = (BOR_CFG_I == `RCS_BOR_CFG_SW);

  // priority: power-on, brown-out, pin, watchdog, instruction, stack, wake
  always_comb begin
    st_d         = st_q;
    st_d.pc_load = 1'b0;
    st_d.grp     = rcs_pkg::RCS_GRP_NONE;
    // software write to the flags; hardware events below win over it
    if (SW_WR_I) begin
      if (SW_WMASK_I[0]) st_d.ri  = SW_WDATA_I[0];
      if (SW_WMASK_I[1]) st_d.to  = SW_WDATA_I[1];
      if (SW_WMASK_I[2]) st_d.pd  = SW_WDATA_I[2];
      if (SW_WMASK_I[3]) st_d.po  = SW_WDATA_I[3];
      if (SW_WMASK_I[4]) st_d.bo  = SW_WDATA_I[4];
      if (SW_WMASK_I[5]) st_d.sf  = SW_WDATA_I[5];
      if (SW_WMASK_I[6]) st_d.su  = SW_WDATA_I[6];
      if (SW_WMASK_I[7]) st_d.sbo = SW_WDATA_I[7] & sw_bor_mode;
    end
    // keep register is never reset; it just takes software data
    if (SW_WR_I) st_d.keepreg = DEF_WDATA_I;
    else if (SW_WR_I == 1'b0 && SW_WMASK_I == 8'h00) st_d.defreg = st_q.defreg;
    if (ev_por) begin
      st_d.pc  = `RCS_PC_RESET;
      st_d.ri  = 1'b1;
      st_d.to  = 1'b1;
      st_d.pd  = 1'b1;
      st_d.po  = 1'b0;
      st_d.bo  = 1'b0;
      st_d.sf  = 1'b0;
      st_d.su  = 1'b0;
      st_d.sbo = sw_bor_mode;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_POWER;
    end else if (ev_bor) begin
      st_d.pc  = `RCS_PC_RESET;
      st_d.ri  = 1'b1;
      st_d.to  = 1'b1;
      st_d.pd  = 1'b1;
      st_d.bo  = 1'b0;
      st_d.sbo = sw_bor_mode & st_q.sbo;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_POWER;
    end else if (ev_master_clear_pin) begin
      st_d.pc = `RCS_PC_RESET;
      if (mode == rcs_pkg::RCS_MODE_RUN) begin
        st_d.to = 1'b1;
      end else if (pm_low) begin
        st_d.to = 1'b1;
        st_d.pd = 1'b0;
      end
      st_d.sbo     = sw_bor_mode & st_q.sbo;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_RESET;
    end else if (WDT_TIMEOUT_I && pm_low) begin
      st_d.pc = CUR_PC_I + `RCS_PC_STEP;
      st_d.to = 1'b0;
      st_d.pd = 1'b0;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_WAKE;
    end else if (WDT_TIMEOUT_I) begin
      st_d.pc  = `RCS_PC_RESET;
      st_d.to  = 1'b0;
      st_d.sbo = sw_bor_mode & st_q.sbo;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_RESET;
    end else if (RESET_INSTR_I) begin
      st_d.pc  = `RCS_PC_RESET;
      st_d.ri  = 1'b0;
      st_d.sbo = sw_bor_mode & st_q.sbo;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_RESET;
    end else if (STACK_FULL_I && STACK_OVERFLOW_RESET_ENABLE_CFG_I) begin
      st_d.pc  = `RCS_PC_RESET;
      st_d.sf  = 1'b1;
      st_d.sbo = sw_bor_mode & st_q.sbo;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_RESET;
    end else if (STACK_UNDERFLOW_I && STACK_OVERFLOW_RESET_ENABLE_CFG_I) begin
      st_d.pc  = `RCS_PC_RESET;
      st_d.su  = 1'b1;
      st_d.sbo = sw_bor_mode & st_q.sbo;
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_RESET;
    end else if (STACK_UNDERFLOW_I) begin
      st_d.su = 1'b1;
      st_d.pc = `RCS_PC_RESET;
    end else if (IRQ_WAKE_I && mode != rcs_pkg::RCS_MODE_FULL) begin
      st_d.pd = 1'b0;
      if (HIGH_IRQ_EN_I || LOW_IRQ_EN_I) begin
        st_d.pc = IRQ_HIGH_I ? `RCS_VEC_HIGH : `RCS_VEC_LOW;
      end else begin
        st_d.pc = CUR_PC_I + `RCS_PC_STEP;
      end
      st_d.pc_load = 1'b1;
      st_d.grp     = rcs_pkg::RCS_GRP_WAKE;
    end
    // a bit latched under software control must not linger once the
    // configuration leaves software mode, so it is cleared every cycle
    if (!sw_bor_mode) st_d.sbo = 1'b0;
    // defined register: loaded by reset group, untouched by wake-up
    case (st_d.grp)
      rcs_pkg::RCS_GRP_POWER: st_d.defreg = `RCS_DEF_RST_POR;
      rcs_pkg::RCS_GRP_RESET: st_d.defreg = `RCS_DEF_RST_OTHER;
      rcs_pkg::RCS_GRP_WAKE:  st_d.defreg = st_q.defreg;
      default: begin
        if (SW_WR_I) st_d.defreg = DEF_WDATA_I;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; keep register has no reset so it survives resets
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st_q.ri      <= 1'b1;
      st_q.to      <= 1'b1;
      st_q.pd      <= 1'b1;
      st_q.po      <= 1'b0;
      st_q.bo      <= 1'b0;
      st_q.sf      <= 1'b0;
      st_q.su      <= 1'b0;
      st_q.sbo     <= 1'b0;
      st_q.pc      <= `RCS_PC_RESET;
      st_q.pc_load <= 1'b0;
      st_q.grp     <= rcs_pkg::RCS_GRP_NONE;
      st_q.defreg  <= `RCS_DEF_RST_POR;
    end else begin
      st_q.ri      <= st_d.ri;
      st_q.to      <= st_d.to;
      st_q.pd      <= st_d.pd;
      st_q.po      <= st_d.po;
      st_q.bo      <= st_d.bo;
      st_q.sf      <= st_d.sf;
      st_q.su      <= st_d.su;
      st_q.sbo     <= st_d.sbo;
      st_q.pc      <= st_d.pc;
      st_q.pc_load <= st_d.pc_load;
      st_q.grp     <= st_d.grp;
      st_q.defreg  <= st_d.defreg;
    end
    st_q.keepreg <= st_d.keepreg;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs come straight from the state flops; CORE_RESET_O decodes the group
  assign RESET_INSTR_FLAG_O     = st_q.ri;
  assign WDT_TIMEOUT_FLAG_O     = st_q.to;
  assign POWERDOWN_FLAG_O       = st_q.pd;
  assign POWERON_FLAG_O         = st_q.po;
  assign BROWNOUT_FLAG_O        = st_q.bo;
  assign STACK_FULL_FLAG_O      = st_q.sf;
  assign STACK_UNDERFLOW_FLAG_O = st_q.su;
  assign SW_BOR_EN_O            = st_q.sbo;
  assign PC_O                   = st_q.pc;
  assign PC_LOAD_O              = st_q.pc_load;
  assign CORE_RESET_O           = st_q.grp == rcs_pkg::RCS_GRP_POWER ||
                                  st_q.grp == rcs_pkg::RCS_GRP_RESET;
  assign RESET_GROUP_O          = st_q.grp;
  assign DEF_REG_O              = st_q.defreg;
  assign KEEP_REG_O             = st_q.keepreg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_por_flags;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    ev_por |=> st_q.ri && st_q.to && st_q.pd && !st_q.po && !st_q.bo &&
               !st_q.sf && !st_q.su && st_q.pc == `RCS_PC_RESET;
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("power-on flags wrong");

  property p_bor_keep_po;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (ev_bor && !ev_por) |=> !st_q.bo && st_q.ri &&
                             st_q.po == $past(st_q.po);
  endproperty
  a_bor_keep_po: assert property (p_bor_keep_po)
    else $error("brown-out flags wrong");

  property p_wdt_wake;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (WDT_TIMEOUT_I && pm_low && !ev_por && !ev_bor && !ev_master_clear_pin) |=>
      !st_q.to && !st_q.pd && st_q.grp == rcs_pkg::RCS_GRP_WAKE &&
      st_q.pc == $past(CUR_PC_I) + `RCS_PC_STEP;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog wake-up wrong");

  property p_sbo_zero;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !sw_bor_mode ##1 !sw_bor_mode |-> !st_q.sbo;
  endproperty
  a_sbo_zero: assert property (p_sbo_zero)
    else $error("software brownout enable not zero");

  property p_su_err;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (STACK_UNDERFLOW_I && !STACK_OVERFLOW_RESET_ENABLE_CFG_I && !ev_por && !ev_bor && !ev_master_clear_pin &&
     !WDT_TIMEOUT_I && !RESET_INSTR_I && !STACK_FULL_I) |=>
      st_q.su && !st_q.pc_load;
  endproperty
  a_su_err: assert property (p_su_err)
    else $error("underflow error handling wrong");

  property p_ri_clr;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (RESET_INSTR_I && !ev_por && !ev_bor && !ev_master_clear_pin && !WDT_TIMEOUT_I) |=>
      !st_q.ri && st_q.to == $past(st_q.to) && st_q.pc_load;
  endproperty
  a_ri_clr: assert property (p_ri_clr)
    else $error("reset instruction handling wrong");

  property p_wake_def;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    st_d.grp == rcs_pkg::RCS_GRP_WAKE |=> st_q.defreg == $past(st_q.defreg);
  endproperty
  a_wake_def: assert property (p_wake_def)
    else $error("wake-up changed defined register");

  property p_reset_def;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    st_d.grp == rcs_pkg::RCS_GRP_RESET |=> st_q.defreg == `RCS_DEF_RST_OTHER;
  endproperty
  a_reset_def: assert property (p_reset_def)
    else $error("defined register not reset");

endmodule
`default_nettype wire

//--- testbench/rcs_top_tb.sv
// self-checking bench for the reset cause status logic
`timescale 1ns/100ps
`default_nettype none
module rcs_top_tb;
  ////////////////////////////////////////////////////////////////////////
  // one row: event mask, context, flag preload and expected outcome
  typedef struct packed {
    logic [7:0]  ev;
    logic [1:0]  mode;
    logic        stv;
    logic [1:0]  gie;
    logic        ih;
    logic [1:0]  sw;
    logic [6:0]  pre;
    logic [6:0]  exp;
    logic [20:0] pc;
    logic        ld;
    logic [1:0]  grp;
  } rcs_row_t;

  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic [7:0]  ev   = 8'h00;
  logic [5:0]  ctl  = 6'h00;
  logic [1:0]  bcfg = 2'h2;
  logic        swr  = 1'b0;
  logic [7:0]  wdat = 8'h00;
  logic [7:0]  dwd  = 8'h00;
  wire  [6:0]  flags;
  wire  [20:0] pc;
  wire  [1:0]  grp;
  wire  [7:0]  defr;
  wire  [7:0]  keepr;
  wire         ld;
  wire         crst;
  wire         sbo;
  int          errors      = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  rcs_row_t    rows [19];

  always #5 clk = ~clk;

  // event mask bits: por, bor, pin, watchdog, instr, full, underflow, irq
  rcs_top DUT (
    .CLK_I                  (clk),
    .SYS_RST_I              (rst),
    .POR_I                  (ev[0]),
    .BOR_I                  (ev[1]),
    .MASTER_CLEAR_PIN_I                 (ev[2]),
    .WDT_TIMEOUT_I          (ev[3]),
    .RESET_INSTR_I          (ev[4]),
    .STACK_FULL_I           (ev[5]),
    .STACK_UNDERFLOW_I      (ev[6]),
    .IRQ_WAKE_I             (ev[7]),
    .POWER_MODE_I           (ctl[5:4]),
    .STACK_OVERFLOW_RESET_ENABLE_CFG_I           (ctl[3]),
    .BOR_CFG_I              (bcfg),
    .HIGH_IRQ_EN_I          (ctl[2]),
    .LOW_IRQ_EN_I           (ctl[1]),
    .IRQ_HIGH_I             (ctl[0]),
    .CUR_PC_I               (21'h000100),
    .SW_WR_I                (swr),
    .SW_WDATA_I             (wdat),
    .SW_WMASK_I             (8'hff),
    .DEF_WDATA_I            (dwd),
    .RESET_INSTR_FLAG_O     (flags[0]),
    .WDT_TIMEOUT_FLAG_O     (flags[1]),
    .POWERDOWN_FLAG_O       (flags[2]),
    .POWERON_FLAG_O         (flags[3]),
    .BROWNOUT_FLAG_O        (flags[4]),
    .STACK_FULL_FLAG_O      (flags[5]),
    .STACK_UNDERFLOW_FLAG_O (flags[6]),
    .SW_BOR_EN_O            (sbo),
    .PC_O                   (pc),
    .PC_LOAD_O              (ld),
    .CORE_RESET_O           (crst),
    .RESET_GROUP_O          (grp),
    .DEF_REG_O              (defr),
    .KEEP_REG_O             (keepr)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang is cut short well above the hundred or so cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      summarize();
    end
  end

  task automatic cmp_flags(input logic [6:0] got, input logic [6:0] want);
    checks_done++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t flags %h want %h", $time, got, want);
    end
  endtask

  task automatic cmp_pc(input logic [20:0] got, input logic [20:0] want);
    checks_done++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t pc %h want %h", $time, got, want);
    end
  endtask

  task automatic cmp_val(input string nm, input logic [7:0] got,
                         input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t %s %h want %h", $time, nm, got, want);
    end
  endtask

  function automatic rcs_row_t mk(input int e, m, s, g, h, w, p, x, c, l, k);
    return rcs_row_t'({8'(e), 2'(m), 1'(s), 2'(g), 1'(h), 2'(w), 7'(p),
                       7'(x), 21'(c), 1'(l), 2'(k)});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // preload flags by software write so that unchanged bits are visible
  task automatic run_row(input rcs_row_t r);
    logic seen;
    logic sbw;
    seen = 1'b0;
    sbw = r.sw[1] & r.sw[0];
    @(posedge clk);
    ctl <= {r.mode, r.stv, r.gie, r.ih};
    bcfg <= r.sw[1] ? 2'h1 : 2'h2;
    swr <= 1'b1;
    wdat <= {r.sw[0], r.pre};
    dwd <= 8'h3c;
    @(posedge clk);
    swr <= 1'b0;
    ev <= r.ev;
    @(negedge clk);
    cmp_flags(flags, r.pre);
    cmp_val("sbo", {7'h0, sbo}, {7'h0, sbw});
    @(posedge clk);
    ev <= 8'h00;
    // pin events pass a synchroniser, so allow a few cycles
    for (int n = 0; n < 6 && !seen; n++) begin
      @(negedge clk);
      if (ld === 1'b1) begin
        seen = 1'b1;
        cmp_val("grp", {6'h0, grp}, {6'h0, r.grp});
        cmp_val("core", {7'h0, crst}, {7'h0, r.grp != 2'h3});
      end
    end
    cmp_val("load", {7'h0, seen}, {7'h0, r.ld});
    cmp_flags(flags, r.exp);
    cmp_pc(pc, r.pc);
    cmp_val("sbo", {7'h0, sbo}, {7'h0, (r.ev[0] & r.sw[1]) | sbw});
    cmp_val("def", defr, (r.ld && r.grp != 2'h3) ? 8'h00 : 8'h3c);
    if (r.grp != 2'h1) begin
      cmp_val("keep", keepr, 8'h3c);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0]  = mk(8'h01, 0, 0, 0, 0, 2, 7'h7f, 7'h07, 21'h0, 1, 1);
    rows[1]  = mk(8'h02, 0, 0, 0, 0, 2, 7'h78, 7'h6f, 21'h0, 1, 1);
    rows[2]  = mk(8'h04, 0, 0, 0, 0, 3, 7'h55, 7'h55, 21'h0, 1, 2);
    rows[3]  = mk(8'h04, 1, 0, 0, 0, 0, 7'h00, 7'h02, 21'h0, 1, 2);
    rows[4]  = mk(8'h04, 2, 0, 0, 0, 0, 7'h04, 7'h02, 21'h0, 1, 2);
    rows[5]  = mk(8'h04, 3, 0, 0, 0, 0, 7'h7c, 7'h7a, 21'h0, 1, 2);
    rows[6]  = mk(8'h08, 0, 0, 0, 0, 0, 7'h7f, 7'h7d, 21'h0, 1, 2);
    rows[7]  = mk(8'h08, 1, 0, 0, 0, 0, 7'h02, 7'h00, 21'h0, 1, 2);
    rows[8]  = mk(8'h10, 0, 0, 0, 0, 1, 7'h7f, 7'h7e, 21'h0, 1, 2);
    rows[9]  = mk(8'h20, 0, 1, 0, 0, 0, 7'h00, 7'h20, 21'h0, 1, 2);
    rows[10] = mk(8'h40, 0, 1, 0, 0, 0, 7'h00, 7'h40, 21'h0, 1, 2);
    rows[11] = mk(8'h18, 0, 0, 0, 0, 0, 7'h7f, 7'h7d, 21'h0, 1, 2);
    rows[12] = mk(8'h08, 2, 0, 0, 0, 0, 7'h06, 7'h00, 21'h102, 1, 3);
    rows[13] = mk(8'h08, 3, 0, 0, 0, 0, 7'h7f, 7'h79, 21'h102, 1, 3);
    rows[14] = mk(8'h80, 2, 0, 0, 0, 0, 7'h7f, 7'h7b, 21'h102, 1, 3);
    rows[15] = mk(8'h80, 3, 0, 2, 1, 0, 7'h04, 7'h00, 21'h8, 1, 3);
    rows[16] = mk(8'h80, 1, 0, 1, 0, 0, 7'h7f, 7'h7b, 21'h18, 1, 3);
    rows[17] = mk(8'h40, 0, 0, 0, 0, 0, 7'h00, 7'h40, 21'h0, 0, 0);
    rows[18] = mk(8'h80, 0, 0, 0, 0, 0, 7'h7f, 7'h7f, 21'h0, 0, 0);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp_flags(flags, 7'h07);
    cmp_pc(pc, 21'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("test %0d done", i);
    end
    // software enable must drop once software control is deselected
    @(posedge clk);
    bcfg <= 2'h1;
    swr  <= 1'b1;
    wdat <= 8'h80;
    @(posedge clk);
    swr  <= 1'b0;
    @(negedge clk);
    cmp_val("sbo", {7'h0, sbo}, 8'h01);
    @(posedge clk);
    bcfg <= 2'h2;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_val("sbo", {7'h0, sbo}, 8'h00);
    $display("test sbo config done");
    // a second reset in mid-run must reload the defined register
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp_flags(flags, 7'h07);
    cmp_val("def", defr, 8'h00);
    cmp_val("keep", keepr, 8'h3c);
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
